// >>> display_reset_ctl.sv
// Reset sequencing, defaults and pin gating for the display driver
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "rst_ctl_params.svh"
module display_reset_ctl #(
	parameter int unsigned NV_CYC = `MS_CYC(`T_NV_MS),
	parameter int unsigned BLANK_CYC = `MS_CYC(`T_BLANK_MS)
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic POWER_OFF_I,
	input wire logic RESET_N_PIN_I,
	input wire logic CHIP_SELECT_N_I,
	input wire logic DATA_CMD_SEL_I,
	input wire logic WRITE_STROBE_N_I,
	input wire logic READ_STROBE_N_I,
	input wire logic [17:0] PARALLEL_DATA_BUS_I,
	input wire logic DRIVE_REQ_I,
	input wire logic [17:0] CORE_DB_I,
	input wire logic VBLANK_I,
	input wire logic HBLANK_I,
	input wire logic NV_LOAD_DONE_I,
	input wire rst_ctl_pkg::addr_t REG_ADDR_I,
	input wire rst_ctl_pkg::word_t REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output rst_ctl_pkg::word_t REG_RDATA_O,
	output logic CORE_CHIP_SELECT_N_O,
	output logic CORE_DATA_CMD_SEL_O,
	output logic CORE_WRITE_STROBE_N_O,
	output logic CORE_READ_STROBE_N_O,
	output logic [17:0] CORE_DB_O,
	output logic [17:0] PARALLEL_DATA_BUS_O,
	output logic PARALLEL_DATA_BUS_OE_O,
	output logic TEAR_SYNC_OUT_O,
	output logic DISPLAY_BLANK_O,
	output logic NV_LOAD_REQ_O,
	output logic READY_O
);
	import rst_ctl_pkg::*;

	rst_state_e state_reg;
	rst_state_e state_next;
	logic pin_n_filt;
	logic [`TMR_W-1:0] tmr_cnt;
	logic [`POR_W-1:0] por_cnt_reg;
	logic ready;
	logic accept;
	logic hw_hold;
	logic sw_apply;
	logic wr_ok;
	logic por_done;
	logic awake_reg;
	logic sleep_out_reg;
	logic disp_on_reg;
	logic idle_reg;
	logic partial_reg;
	logic tear_on_reg;
	logic tear_mode_reg;
	logic [1:0] gamma_reg;
	logic [15:0] col_start_reg;
	logic [15:0] col_end_reg;
	logic [15:0] page_start_reg;
	logic [15:0] page_end_reg;
	logic [15:0] part_start_reg;
	logic [15:0] part_end_reg;
	logic [7:0] memory_access_ctl_reg;
	logic [7:0] access_ctl_readback_reg;
	logic [7:0] pixel_format_readback_reg;
	logic [7:0] power_mode_readback;
	logic [7:0] signal_mode_readback;
	word_t rd_word;

	function automatic logic reached(input logic [`TMR_W-1:0] cnt,
		input int unsigned lim);
		return cnt >= `TMR_W'(lim);
	endfunction

	function automatic logic [15:0] sw_end(input logic xchg,
		input logic [15:0] plain, input logic [15:0] swapped);
		return xchg ? swapped : plain;
	endfunction

	reset_pin_filter u_filter (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.pin_n_i(RESET_N_PIN_I),
		.filt_n_o(pin_n_filt)
	);

	cycle_timer u_timer (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.run_i(state_reg == ST_RELOAD || state_reg == ST_SETTLE),
		.count_o(tmr_cnt)
	);

	assign ready = state_reg == ST_READY;
	assign accept = ready && !POWER_OFF_I;
	assign hw_hold = state_reg == ST_PIN_LOW;
	assign wr_ok = accept && REG_WR_I;
	assign sw_apply = wr_ok && REG_ADDR_I == `A_SWRST;
	assign por_done = por_cnt_reg == `POR_W'(`POR_CYC - 1);

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			por_cnt_reg <= '0;
		else if (state_reg == ST_POR && !por_done)
			por_cnt_reg <= por_cnt_reg + `POR_W'(1);
	end

	always_comb
	begin
		state_next = state_reg;
		if (!pin_n_filt)
			state_next = ST_PIN_LOW;
		else
		begin
			case (state_reg)
				ST_POR:
					if (por_done)
						state_next = ST_READY;
				ST_READY:
					if (sw_apply)
						state_next = ST_SETTLE;
				ST_PIN_LOW:
					state_next = ST_RELOAD;
				ST_RELOAD:
					if (NV_LOAD_DONE_I || reached(tmr_cnt, NV_CYC))
						state_next = awake_reg ? ST_SETTLE : ST_READY;
				ST_SETTLE:
					if (reached(tmr_cnt, awake_reg ? BLANK_CYC : NV_CYC))
						state_next = ST_READY;
				default:
					state_next = ST_POR;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			state_reg <= ST_POR;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			awake_reg <= 1'b0;
		else if (ready && (!pin_n_filt || sw_apply))
			awake_reg <= sleep_out_reg;
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I || hw_hold || sw_apply)
		begin
			sleep_out_reg <= 1'b0;
			disp_on_reg <= 1'b0;
			idle_reg <= 1'b0;
			partial_reg <= 1'b0;
			tear_on_reg <= 1'b0;
			tear_mode_reg <= 1'b0;
			gamma_reg <= `GAMMA_RST;
		end
		else if (wr_ok && REG_ADDR_I == `A_CTRL)
		begin
			sleep_out_reg <= REG_WDATA_I[`B_SLPOUT];
			disp_on_reg <= REG_WDATA_I[`B_DISPON];
			idle_reg <= REG_WDATA_I[`B_IDLE];
			partial_reg <= REG_WDATA_I[`B_PARTIAL];
			tear_on_reg <= REG_WDATA_I[`B_TEON];
			tear_mode_reg <= REG_WDATA_I[`B_TEMODE];
			gamma_reg <= REG_WDATA_I[`B_GAMMA];
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I || hw_hold)
		begin
			col_start_reg <= `START_RST;
			col_end_reg <= `COL_END_RST;
			page_start_reg <= `START_RST;
			page_end_reg <= `PAGE_END_RST;
		end
		else if (sw_apply)
		begin
			col_start_reg <= `START_RST;
			col_end_reg <= sw_end(memory_access_ctl_reg[`XCHG_BIT],
				`COL_END_RST, `PAGE_END_RST);
			page_start_reg <= `START_RST;
			page_end_reg <= sw_end(memory_access_ctl_reg[`XCHG_BIT],
				`PAGE_END_RST, `COL_END_RST);
		end
		else if (wr_ok)
		begin
			if (REG_ADDR_I == `A_COL_START)
				col_start_reg <= REG_WDATA_I;
			if (REG_ADDR_I == `A_COL_END)
				col_end_reg <= REG_WDATA_I;
			if (REG_ADDR_I == `A_PAGE_START)
				page_start_reg <= REG_WDATA_I;
			if (REG_ADDR_I == `A_PAGE_END)
				page_end_reg <= REG_WDATA_I;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I || hw_hold || sw_apply)
		begin
			part_start_reg <= `START_RST;
			part_end_reg <= `PART_END_RST;
		end
		else if (wr_ok && REG_ADDR_I == `A_PART_START)
			part_start_reg <= REG_WDATA_I;
		else if (wr_ok && REG_ADDR_I == `A_PART_END)
			part_end_reg <= REG_WDATA_I;
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I || hw_hold)
		begin
			memory_access_ctl_reg <= `ACC_CTL_RST;
			access_ctl_readback_reg <= `ACC_CTL_RST;
		end
		else if (wr_ok && REG_ADDR_I == `A_ACC_CTL)
		begin
			memory_access_ctl_reg <= REG_WDATA_I[7:0];
			access_ctl_readback_reg <= REG_WDATA_I[7:0];
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I || hw_hold || sw_apply)
			pixel_format_readback_reg <= `PIXFMT_RST;
		else if (wr_ok && REG_ADDR_I == `A_PIXFMT)
			pixel_format_readback_reg <= REG_WDATA_I[7:0];
	end

	always_comb
	begin
		power_mode_readback = 8'h00;
		power_mode_readback[6] = idle_reg;
		power_mode_readback[4] = sleep_out_reg;
		power_mode_readback[3] = !partial_reg;
		power_mode_readback[2] = disp_on_reg;
		signal_mode_readback = {tear_on_reg, tear_mode_reg, 6'h00};
	end

	always_comb
	begin
		case (REG_ADDR_I)
			`A_CTRL:
				rd_word = {8'h00, gamma_reg, tear_mode_reg, tear_on_reg,
					partial_reg, idle_reg, disp_on_reg, sleep_out_reg};
			`A_ACC_CTL: rd_word = {8'h00, memory_access_ctl_reg};
			`A_COL_START: rd_word = col_start_reg;
			`A_COL_END: rd_word = col_end_reg;
			`A_PAGE_START: rd_word = page_start_reg;
			`A_PAGE_END: rd_word = page_end_reg;
			`A_PART_START: rd_word = part_start_reg;
			`A_PART_END: rd_word = part_end_reg;
			`A_PIXFMT: rd_word = {8'h00, pixel_format_readback_reg};
			`A_PWR_RB: rd_word = {8'h00, power_mode_readback};
			`A_ACC_RB: rd_word = {8'h00, access_ctl_readback_reg};
			`A_IMG_RB: rd_word = {8'h00, `IMG_RST};
			`A_SIG_RB: rd_word = {8'h00, signal_mode_readback};
			`A_DIAG_RB: rd_word = {8'h00, `DIAG_RST};
			`A_STATUS: rd_word = {13'h0000, awake_reg, NV_LOAD_REQ_O, ready};
			default: rd_word = 16'h0000;
		endcase
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			REG_RDATA_O <= 16'h0000;
		else if (REG_RD_I)
			REG_RDATA_O <= rd_word;
		else
			REG_RDATA_O <= 16'h0000;
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			CORE_CHIP_SELECT_N_O <= 1'b1;
			CORE_DATA_CMD_SEL_O <= 1'b0;
			CORE_WRITE_STROBE_N_O <= 1'b1;
			CORE_READ_STROBE_N_O <= 1'b1;
			CORE_DB_O <= 18'h00000;
		end
		else
		begin
			CORE_CHIP_SELECT_N_O <= !accept || CHIP_SELECT_N_I;
			CORE_DATA_CMD_SEL_O <= accept && DATA_CMD_SEL_I;
			CORE_WRITE_STROBE_N_O <= !accept || WRITE_STROBE_N_I;
			CORE_READ_STROBE_N_O <= !accept || READ_STROBE_N_I;
			CORE_DB_O <= accept ? PARALLEL_DATA_BUS_I : 18'h00000;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			PARALLEL_DATA_BUS_OE_O <= 1'b0;
			PARALLEL_DATA_BUS_O <= 18'h00000;
		end
		else
		begin
			PARALLEL_DATA_BUS_OE_O <= accept && DRIVE_REQ_I;
			PARALLEL_DATA_BUS_O <= accept ? CORE_DB_I : 18'h00000;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			TEAR_SYNC_OUT_O <= 1'b0;
		else
			TEAR_SYNC_OUT_O <= ready && tear_on_reg &&
				(VBLANK_I || (tear_mode_reg && HBLANK_I));
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			DISPLAY_BLANK_O <= 1'b1;
			NV_LOAD_REQ_O <= 1'b0;
			READY_O <= 1'b0;
		end
		else
		begin
			DISPLAY_BLANK_O <= state_next != ST_READY || !disp_on_reg;
			NV_LOAD_REQ_O <= state_next == ST_RELOAD;
			READY_O <= state_next == ST_READY;
		end
	end

	por_time_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(state_reg == ST_POR && por_done && pin_n_filt)
		|=> state_reg == ST_READY)
		else $error("power-on reset did not finish in time");

	mode_defs_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(hw_hold || sw_apply) |=> (!sleep_out_reg && !disp_on_reg &&
		!idle_reg && !partial_reg && gamma_reg == `GAMMA_RST))
		else $error("mode defaults wrong after reset");

	sw_window_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		sw_apply && memory_access_ctl_reg[`XCHG_BIT]
		|=> col_end_reg == `PAGE_END_RST && page_end_reg == `COL_END_RST)
		else $error("exchanged window ends wrong after soft reset");

	hw_window_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		hw_hold |=> col_end_reg == `COL_END_RST &&
		page_end_reg == `PAGE_END_RST && col_start_reg == `START_RST)
		else $error("window wrong after hard reset");

	access_keep_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		sw_apply |=> $stable(memory_access_ctl_reg) &&
		$stable(access_ctl_readback_reg))
		else $error("soft reset changed access control");

	readback_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(hw_hold || sw_apply) |=> power_mode_readback == 8'h08 &&
		pixel_format_readback_reg == `PIXFMT_RST &&
		signal_mode_readback == 8'h00)
		else $error("readback values wrong after reset");

	tear_low_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!ready |=> !TEAR_SYNC_OUT_O)
		else $error("tearing sync driven during reset");

	db_off_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(!ready || POWER_OFF_I) |=> !PARALLEL_DATA_BUS_OE_O)
		else $error("data bus driven during reset");

	pins_gate_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!accept |=> CORE_CHIP_SELECT_N_O && CORE_WRITE_STROBE_N_O)
		else $error("bus pins passed while not accepted");

	reload_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		state_reg == ST_PIN_LOW && pin_n_filt
		|=> state_reg == ST_RELOAD ##0 NV_LOAD_REQ_O)
		else $error("reload not started on pin release");

	release_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		state_reg == ST_SETTLE && !awake_reg && pin_n_filt &&
		reached(tmr_cnt, NV_CYC) |=> ready)
		else $error("release from sleep-in overran");

	blank_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!ready |-> DISPLAY_BLANK_O)
		else $error("display not blank during reset");
endmodule

// >>> rst_ctl_params.svh
// Timing, offsets and reset values for the display reset controller
`ifndef RST_CTL_PARAMS_SVH
`define RST_CTL_PARAMS_SVH

`define CLK_MHZ 125
`define T_FILT_US 5
`define FILT_CYC (`T_FILT_US * `CLK_MHZ)
`define T_POR_US 10
`define POR_CYC (`T_POR_US * `CLK_MHZ)
`define T_NV_MS 5
`define T_BLANK_MS 120
`define MS_CYC(ms) ((ms) * 1000 * `CLK_MHZ)

`define TMR_W 24
`define FILT_W 11
`define POR_W 11

`define A_CTRL 5'h00
`define A_ACC_CTL 5'h01
`define A_COL_START 5'h02
`define A_COL_END 5'h03
`define A_PAGE_START 5'h04
`define A_PAGE_END 5'h05
`define A_PART_START 5'h06
`define A_PART_END 5'h07
`define A_PIXFMT 5'h08
`define A_PWR_RB 5'h09
`define A_ACC_RB 5'h0a
`define A_IMG_RB 5'h0b
`define A_SIG_RB 5'h0c
`define A_DIAG_RB 5'h0d
`define A_STATUS 5'h0e
`define A_SWRST 5'h0f

`define B_SLPOUT 0
`define B_DISPON 1
`define B_IDLE 2
`define B_PARTIAL 3
`define B_TEON 4
`define B_TEMODE 5
`define B_GAMMA 7:6
`define XCHG_BIT 5

`define START_RST 16'h0000
`define COL_END_RST 16'h00ef
`define PAGE_END_RST 16'h013f
`define PART_END_RST 16'h013f
`define ACC_CTL_RST 8'h00
`define PIXFMT_RST 8'h06
`define IMG_RST 8'h00
`define DIAG_RST 8'h00
`define GAMMA_RST 2'h0

`endif

// >>> rst_ctl_pkg.sv
// Types shared by the display reset controller
package rst_ctl_pkg;
	typedef logic [15:0] word_t;
	typedef logic [4:0] addr_t;
	typedef enum {ST_POR, ST_READY, ST_PIN_LOW, ST_RELOAD, ST_SETTLE}
		rst_state_e;
endpackage

// >>> reset_pin_filter.sv
// Synchroniser and spike filter for the external reset pin
`timescale 1ns/1ps
`include "rst_ctl_params.svh"
module reset_pin_filter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_n_i,
	output logic filt_n_o
);
	logic sync1_reg;
	logic sync2_reg;
	logic [`FILT_W-1:0] cnt_reg;
	logic flip;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end
		else
		begin
			sync1_reg <= pin_n_i;
			sync2_reg <= sync1_reg;
		end
	end

	assign flip = (sync2_reg != filt_n_o) &&
		(cnt_reg == `FILT_W'(`FILT_CYC - 1));

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_reg <= '0;
		else if (sync2_reg == filt_n_o || flip)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + `FILT_W'(1);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			filt_n_o <= 1'b1;
		else if (flip)
			filt_n_o <= sync2_reg;
	end

	flip_len_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(filt_n_o) |-> $past(cnt_reg) == `FILT_W'(`FILT_CYC - 1))
		else $error("filtered reset changed before 5us");

	spike_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!filt_n_o && sync2_reg &&
		cnt_reg != `FILT_W'(`FILT_CYC - 1)) ##1 !sync2_reg |=> !filt_n_o)
		else $error("short high spike ended the reset");
endmodule

// >>> cycle_timer.sv
// Saturating cycle counter that runs while enabled
`timescale 1ns/1ps
`include "rst_ctl_params.svh"
module cycle_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	output logic [`TMR_W-1:0] count_o
);
	// Saturation keeps a stalled sequence from wrapping to zero
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count_o <= '0;
		else if (!run_i)
			count_o <= '0;
		else if (count_o != '1)
			count_o <= count_o + `TMR_W'(1);
	end
endmodule

// >>> host_model.sv
// Host side model: drives the reset pin and answers the reload request
`timescale 1ns/1ps
module host_model #(
	parameter int unsigned NV_DELAY = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic nv_req_i,
	output logic reset_n_o,
	output logic nv_done_o
);
	int unsigned wait_cnt;

	initial reset_n_o = 1'b1;

	task automatic hold_low(input int n, input int spike_at, input int spike_len);
		@(posedge clk_i);
		reset_n_o <= 1'b0;
		for (int i = 1; i < n; i++)
		begin
			@(posedge clk_i);
			if (spike_len > 0 && i == spike_at)
				reset_n_o <= 1'b1;
			if (spike_len > 0 && i == spike_at + spike_len)
				reset_n_o <= 1'b0;
		end
	endtask

	task automatic release_pin();
		@(posedge clk_i);
		reset_n_o <= 1'b1;
	endtask

	// one-cycle load done after a fixed delay
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i || !nv_req_i)
		begin
			wait_cnt <= 0;
			nv_done_o <= 1'b0;
		end
		else
		begin
			wait_cnt <= wait_cnt + 1;
			nv_done_o <= (wait_cnt == NV_DELAY - 1);
		end
	end
endmodule

// >>> display_reset_ctl_test.sv
// Self-checking bench for the display reset controller
`timescale 1ns/1ps
`include "rst_ctl_params.svh"
module display_reset_ctl_test;
	import rst_ctl_pkg::*;
	localparam int NV_T = 40;
	localparam int BLANK_T = 100;
	localparam int NV_D = 12;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pwr_off = 1'b0, cs_n = 1'b1, dc = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
	logic [17:0] db_in = '0, core_db = '0, core_db_o, bus_o;
	logic drive_req = 1'b0, vblank = 1'b0, hblank = 1'b0;
	addr_t addr = '0;
	word_t wdata = '0, rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic core_cs_n, core_dc, core_wr_n, core_rd_n, oe, tear, blank;
	logic nv_req, ready, nv_done, pin_n;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;

	always #4 clk = ~clk;

	display_reset_ctl #(.NV_CYC(NV_T), .BLANK_CYC(BLANK_T)) dut_u (
		.CORE_CLK_I(clk), .RST_I(rst), .POWER_OFF_I(pwr_off),
		.RESET_N_PIN_I(pin_n), .CHIP_SELECT_N_I(cs_n),
		.DATA_CMD_SEL_I(dc), .WRITE_STROBE_N_I(wr_n),
		.READ_STROBE_N_I(rd_n), .PARALLEL_DATA_BUS_I(db_in),
		.DRIVE_REQ_I(drive_req), .CORE_DB_I(core_db), .VBLANK_I(vblank),
		.HBLANK_I(hblank), .NV_LOAD_DONE_I(nv_done), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
		.REG_RDATA_O(rdata), .CORE_CHIP_SELECT_N_O(core_cs_n),
		.CORE_DATA_CMD_SEL_O(core_dc), .CORE_WRITE_STROBE_N_O(core_wr_n),
		.CORE_READ_STROBE_N_O(core_rd_n), .CORE_DB_O(core_db_o),
		.PARALLEL_DATA_BUS_O(bus_o), .PARALLEL_DATA_BUS_OE_O(oe),
		.TEAR_SYNC_OUT_O(tear), .DISPLAY_BLANK_O(blank),
		.NV_LOAD_REQ_O(nv_req), .READY_O(ready)
	);

	host_model #(.NV_DELAY(NV_D)) host_u (
		.clk_i(clk), .rst_i(rst), .nv_req_i(nv_req),
		.reset_n_o(pin_n), .nv_done_o(nv_done)
	);

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [17:0] seen,
		input logic [17:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input addr_t a, input word_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input addr_t a, input word_t exp, input string what);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(what, 18'(rdata), 18'(exp));
	endtask

	// Cycles until the given flag is high, bounded
	task automatic wait_flag(input bit want_ready, input int lim, output int n);
		n = 0;
		while ((want_ready ? ready : nv_req) !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		#1;
	endtask

	task automatic defaults(input word_t cend, input word_t pend,
		input word_t acc);
		rd(`A_CTRL, 16'h0000, "ctrl");
		rd(`A_COL_START, 16'h0000, "col_start");
		rd(`A_COL_END, cend, "col_end");
		rd(`A_PAGE_START, 16'h0000, "page_start");
		rd(`A_PAGE_END, pend, "page_end");
		rd(`A_PART_START, 16'h0000, "part_start");
		rd(`A_PART_END, 16'h013f, "part_end");
		rd(`A_ACC_CTL, acc, "access_ctl");
		rd(`A_ACC_RB, acc, "access_rb");
		rd(`A_PWR_RB, 16'h0008, "power_rb");
		rd(`A_PIXFMT, 16'h0006, "pixfmt");
		rd(`A_IMG_RB, 16'h0000, "image_rb");
		rd(`A_SIG_RB, 16'h0000, "signal_rb");
		rd(`A_DIAG_RB, 16'h0000, "diag_rb");
		chk("tear_after_reset", 18'(tear), 18'h0);
	endtask

	// Spoil every resettable register before a reset
	task automatic dirty(input word_t acc, input word_t ctrl);
		for (int a = 2; a <= 8; a++)
			wr(addr_t'(a), word_t'(a + 1));
		wr(`A_ACC_CTL, acc);
		wr(`A_CTRL, ctrl);
	endtask

	task automatic t_por();
		int n;
		wr(`A_ACC_CTL, 16'h0055);
		wait_flag(1'b1, 1400, n);
		chk("ready_after_por", 18'(ready), 18'h1);
		chk("por_not_early", 18'(n > 1200), 18'h1);
		chk("oe_after_por", 18'(oe), 18'h0);
		defaults(16'h00ef, 16'h013f, 16'h0000);
		$display("power-on test done");
	endtask

	task automatic t_gate();
		@(posedge clk);
		cs_n <= 1'b0;
		dc <= 1'b1;
		wr_n <= 1'b0;
		db_in <= 18'h2a5a5;
		drive_req <= 1'b1;
		core_db <= 18'h15a5a;
		repeat (2) @(posedge clk);
		#1 chk("cs_pass", 18'(core_cs_n), 18'h0);
		chk("dc_pass", 18'(core_dc), 18'h1);
		chk("wr_pass", 18'(core_wr_n), 18'h0);
		chk("db_in_pass", core_db_o, 18'h2a5a5);
		chk("db_out", bus_o, 18'h15a5a);
		chk("oe_ready", 18'(oe), 18'h1);
		@(posedge clk);
		pwr_off <= 1'b1;
		rd_n <= 1'b0;
		wr(`A_ACC_CTL, 16'h0033);
		@(posedge clk);
		#1 chk("cs_off", 18'(core_cs_n), 18'h1);
		chk("dc_off", 18'(core_dc), 18'h0);
		chk("wr_off", 18'(core_wr_n), 18'h1);
		chk("rd_off", 18'(core_rd_n), 18'h1);
		chk("db_in_off", core_db_o, 18'h0);
		chk("oe_power_off", 18'(oe), 18'h0);
		@(posedge clk);
		pwr_off <= 1'b0;
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		rd(`A_ACC_CTL, 16'h0000, "write_in_power_off");
		$display("pin gating test done");
	endtask

	task automatic t_te();
		wr(`A_CTRL, 16'h0010);
		vblank <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("tear_vblank", 18'(tear), 18'h1);
		@(posedge clk);
		vblank <= 1'b0;
		hblank <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("tear_mode_one", 18'(tear), 18'h0);
		wr(`A_CTRL, 16'h0030);
		repeat (2) @(posedge clk);
		#1 chk("tear_mode_two", 18'(tear), 18'h1);
		rd(`A_SIG_RB, 16'h00c0, "signal_rb_live");
		@(posedge clk);
		vblank <= 1'b1;
		$display("tearing test done");
	endtask

	task automatic t_soft();
		int n;
		for (int k = 0; k < 2; k++)
		begin
			dirty(k ? 16'h0020 : 16'h0000, word_t'(16'h0012 | k));
			@(posedge clk);
			#1 chk("blank_on", 18'(blank), 18'h0);
			wr(`A_SWRST, 16'h0001);
			@(posedge clk);
			#1 chk("soft_blank", 18'(blank), 18'h1);
			chk("soft_oe", 18'(oe), 18'h0);
			wait_flag(1'b1, 300, n);
			chk("soft_wait", 18'(n >= (k ? BLANK_T : NV_T) - 4 &&
				n <= (k ? BLANK_T : NV_T) + 4), 18'h1);
			defaults(k ? 16'h013f : 16'h00ef, k ? 16'h00ef : 16'h013f,
				k ? 16'h0020 : 16'h0000);
			rd(`A_STATUS, k ? 16'h0005 : 16'h0001, "status");
		end
		$display("software reset test done");
	endtask

	task automatic t_short();
		int drops;
		drops = 0;
		fork
			begin
				host_u.hold_low(600, 0, 0);
				host_u.release_pin();
			end
			repeat (1300) @(negedge clk) drops += (ready !== 1'b1);
		join
		repeat (700) @(negedge clk) drops += (ready !== 1'b1);
		chk("short_pulse_drops", 18'(drops), 18'h0);
		$display("short pulse test done");
	endtask

	task automatic t_pin();
		int n;
		for (int k = 0; k < 2; k++)
		begin
			dirty(16'h0020, word_t'(16'h0010 | k));
			host_u.hold_low(1300, 700, 300);
			#1 chk("pin_ready", 18'(ready), 18'h0);
			chk("pin_blank", 18'(blank), 18'h1);
			chk("pin_oe", 18'(oe), 18'h0);
			chk("pin_no_reload", 18'(nv_req), 18'h0);
			host_u.release_pin();
			wait_flag(1'b0, 700, n);
			chk("reload_start", 18'(n >= 620 && n <= 640), 18'h1);
			wait_flag(1'b1, 300, n);
			chk("reload_len", 18'(k ? (n >= BLANK_T - 4 && n <= BLANK_T + 4) :
				(n >= NV_D - 2 && n <= NV_D + 4)), 18'h1);
			defaults(16'h00ef, 16'h013f, 16'h0000);
		end
		$display("pin reset test done");
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			$display("[FAIL] run time expected below 20000 seen %0d", cyc);
			end_of_test();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_por();
		t_gate();
		t_te();
		t_soft();
		t_short();
		t_pin();
		end_of_test();
	end
endmodule
